//--- hdl/rrb_cfg.svh
// Offsets, field positions, reset values and timing counts of the RMS result bank
// Assumes a 100 MHz system clock; included by the modules and the testbench
`ifndef RRB_CFG_SVH
`define RRB_CFG_SVH

// Register indices; byte address is four times the index
`define RRB_IDX_RAW_TOT_U     12'h104
`define RRB_IDX_RAW_TOT_I     12'h105
`define RRB_IDX_RAW_MEAS      12'h106
`define RRB_IDX_RAW_FUND_U    12'h109
`define RRB_IDX_RAW_FUND_I    12'h10a
`define RRB_IDX_INST_TOT_U    12'h10d
`define RRB_IDX_INST_TOT_I    12'h10e
`define RRB_IDX_STATUS        12'h1f0
`define RRB_IDX_CTRL          12'h1f1

// Control register fields
`define RRB_CTRL_CLK_SEL_BIT  0
`define RRB_CTRL_SRC_B_BIT    1
// Status register fields
`define RRB_STAT_SETTLED_BIT  0
`define RRB_STAT_SRC_B_BIT    1
`define RRB_STAT_CLK_SEL_BIT  2

`define RRB_RESULT_RESET      32'h0000_0000
`define RRB_CTRL_RESET        2'h0

// Timing in ms at each metering clock rate
`define RRB_UPD_FAST_MS       160
`define RRB_SETTLE_FAST_MS    500
`define RRB_UPD_SLOW_MS       640
`define RRB_SETTLE_SLOW_MS    2000
`define RRB_SYS_CLK_HZ        100000000
// One millisecond tick at the system clock
`define RRB_MS_CYCLES         (`RRB_SYS_CLK_HZ / 1000)

`endif

//--- hdl/rrb_pkg.sv
// Types shared by the RMS result bank
// Assumes rrb_cfg.svh for numeric values
package rrb_pkg;

  // One set of results from the metering datapath
  typedef struct packed {
    logic [31:0] raw_tot_u;
    logic [31:0] raw_tot_ia;
    logic [31:0] raw_tot_ib;
    logic [31:0] raw_meas;
    logic [31:0] raw_fund_u;
    logic [31:0] raw_fund_ia;
    logic [31:0] raw_fund_ib;
    logic [31:0] inst_tot_u;
    logic [31:0] inst_tot_ia;
    logic [31:0] inst_tot_ib;
  } rrb_results_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } rrb_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rrb_axi_rsp_t;

endpackage : rrb_pkg

//--- hdl/rrb_tick.sv
// Refresh and settle timer of the RMS result bank
// Assumes one system clock; the interval follows the metering clock selection
`include "rrb_cfg.svh"

module rrb_tick #(
  parameter int MS_CYCLES = `RRB_MS_CYCLES
) (
  // Clock and reset
  input  wire logic CLK_I,
  input  wire logic RST_N_I,
  // Control
  input  wire logic slow_i,
  input  wire logic restart_i,
  // Events
  output logic      refresh_o,
  output logic      settled_o
);
  import rrb_pkg::*;

  if (MS_CYCLES < 1) begin : g_ms_check
    $error("MS_CYCLES must be at least 1");
  end

  logic [31:0] pre_reg, pre_next;
  logic [15:0] ms_reg, ms_next;
  logic [15:0] age_reg, age_next;
  logic        set_reg, set_next;
  logic        ms_tick;
  logic [15:0] upd_ms, settle_ms;

  assign ms_tick   = (pre_reg == 32'(MS_CYCLES - 1));
  assign upd_ms    = slow_i ? 16'(`RRB_UPD_SLOW_MS) : 16'(`RRB_UPD_FAST_MS);
  assign settle_ms = slow_i ? 16'(`RRB_SETTLE_SLOW_MS) : 16'(`RRB_SETTLE_FAST_MS);

  always_comb begin
    pre_next  = ms_tick ? 32'h0000_0000 : pre_reg + 32'h0000_0001;
    ms_next   = ms_reg;
    age_next  = age_reg;
    set_next  = set_reg;
    if (ms_tick) begin
      ms_next = (ms_reg == upd_ms - 16'h0001) ? 16'h0000 : ms_reg + 16'h0001;
      if (!set_reg) begin
        age_next = age_reg + 16'h0001;
      end
      if (age_reg == settle_ms - 16'h0001) begin
        set_next = 1'b1;
      end
    end
    if (restart_i) begin
      pre_next = 32'h0000_0000;
      ms_next  = 16'h0000;
      age_next = 16'h0000;
      set_next = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pre_reg <= 32'h0000_0000;
      ms_reg  <= 16'h0000;
      age_reg <= 16'h0000;
      set_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      ms_reg  <= ms_next;
      age_reg <= age_next;
      set_reg <= set_next;
    end
  end

  assign refresh_o = ms_tick && (ms_reg == upd_ms - 16'h0001) && !restart_i;
  assign settled_o = set_reg;

  a_tick_refresh_gap: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    refresh_o |=> !refresh_o)
    else $error("refresh pulse lasted more than one cycle");

endmodule : rrb_tick

//--- hdl/rrb_bank.sv
// Function
// - Every result register is 32-bit two's complement and host readable and writable.
// - With the fast metering clock each result refreshes every 160 ms, settled after 500 ms.
// - With the slow metering clock each result refreshes every 640 ms, settled after 2000 ms.
// - Raw total current holds input A or B as the current channel selects.
// - Raw fundamental current follows the current channel's selected input.
// - Instantaneous total current follows the current channel's selected input.
// - A register holds the raw total voltage RMS, refreshed periodically.
// - A register holds the raw fundamental voltage RMS.
// - A register holds the raw RMS of the measurement channel signal.
// - A separate register holds the instantaneous total voltage RMS.
//
// RMS result register bank with an AXI4-Lite slave
// Assumes the metering datapath presents results continuously on RESULTS_I
`include "rrb_cfg.svh"

module rrb_bank #(
  parameter int MS_CYCLES = `RRB_MS_CYCLES
) (
  // Clock and reset
  input  wire logic          CLK_I,
  input  wire logic          RST_N_I,
  // Metering datapath
  input  rrb_pkg::rrb_results_t RESULTS_I,
  // AXI4-Lite slave
  input  rrb_pkg::rrb_axi_req_t AXI_REQ_I,
  output rrb_pkg::rrb_axi_rsp_t AXI_RSP_O,
  // Status
  output logic               REFRESH_O,
  output logic               SETTLED_O
);
  import rrb_pkg::*;

  // A zero-length millisecond would leave the prescaler without a terminal count
  if (MS_CYCLES < 1) begin : g_ms_check
    $error("MS_CYCLES must be at least 1");
  end

  localparam int NREG = 7;

  //////////////////////////////////////////////////////////////////////////////
  // Register map decode
  function automatic logic [3:0] decode(input logic [31:0] addr);
    logic [11:0] idx;
    idx = addr[13:2];
    if (addr[31:14] != 18'h0) begin
      decode = 4'hf;
    end else begin
      case (idx)
        `RRB_IDX_RAW_TOT_U:  decode = 4'h0;
        `RRB_IDX_RAW_TOT_I:  decode = 4'h1;
        `RRB_IDX_RAW_MEAS:   decode = 4'h2;
        `RRB_IDX_RAW_FUND_U: decode = 4'h3;
        `RRB_IDX_RAW_FUND_I: decode = 4'h4;
        `RRB_IDX_INST_TOT_U: decode = 4'h5;
        `RRB_IDX_INST_TOT_I: decode = 4'h6;
        `RRB_IDX_STATUS:     decode = 4'h7;
        `RRB_IDX_CTRL:       decode = 4'h8;
        default:             decode = 4'hf;
      endcase
    end
  endfunction : decode

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    merge = r;
  endfunction : merge

  //////////////////////////////////////////////////////////////////////////////
  // Timer
  logic [1:0] ctrl_reg, ctrl_next;
  logic       refresh, settled, restart;

  rrb_tick #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .CLK_I     (CLK_I),
    .RST_N_I   (RST_N_I),
    .slow_i    (ctrl_reg[`RRB_CTRL_CLK_SEL_BIT]),
    .restart_i (restart),
    .refresh_o (refresh),
    .settled_o (settled)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Write channel state
  typedef enum logic [1:0] {
    RRB_W_IDLE = 2'b00,
    RRB_W_RESP = 2'b01
  } rrb_wstate_t;

  rrb_wstate_t wst_reg, wst_next;
  logic        aw_hold_reg, aw_hold_next;
  logic        w_hold_reg, w_hold_next;
  logic [31:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        aw_take, w_take, do_write;
  logic [31:0] wa;
  logic [31:0] wd;
  logic [3:0]  wb;
  logic [3:0]  wsel;

  assign aw_take  = (wst_reg == RRB_W_IDLE) && !aw_hold_reg && AXI_REQ_I.awvalid;
  assign w_take   = (wst_reg == RRB_W_IDLE) && !w_hold_reg && AXI_REQ_I.wvalid;
  assign wa       = aw_hold_reg ? awaddr_reg : AXI_REQ_I.awaddr;
  assign wd       = w_hold_reg ? wdata_reg : AXI_REQ_I.wdata;
  assign wb       = w_hold_reg ? wstrb_reg : AXI_REQ_I.wstrb;
  assign do_write = (wst_reg == RRB_W_IDLE) && (aw_hold_reg || aw_take)
                    && (w_hold_reg || w_take);
  assign wsel     = decode(wa);
  assign restart  = do_write && (wsel == 4'h8);

  always_comb begin
    wst_next     = wst_reg;
    aw_hold_next = aw_hold_reg | aw_take;
    w_hold_next  = w_hold_reg | w_take;
    awaddr_next  = aw_take ? AXI_REQ_I.awaddr : awaddr_reg;
    wdata_next   = w_take ? AXI_REQ_I.wdata : wdata_reg;
    wstrb_next   = w_take ? AXI_REQ_I.wstrb : wstrb_reg;
    bresp_next   = bresp_reg;
    case (wst_reg)
      RRB_W_IDLE: begin
        if (do_write) begin
          wst_next     = RRB_W_RESP;
          aw_hold_next = 1'b0;
          w_hold_next  = 1'b0;
          bresp_next   = (wsel == 4'hf || wsel == 4'h7) ? 2'h2 : 2'h0;
        end
      end
      RRB_W_RESP: begin
        if (AXI_REQ_I.bready) wst_next = RRB_W_IDLE;
      end
      default: wst_next = RRB_W_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result registers and control
  logic [NREG-1:0][31:0] res_reg, res_next;
  logic                  src_b;

  assign src_b = ctrl_reg[`RRB_CTRL_SRC_B_BIT];

  always_comb begin
    res_next  = res_reg;
    ctrl_next = ctrl_reg;
    if (do_write && wsel < 4'(NREG)) begin
      res_next[wsel[2:0]] = merge(res_reg[wsel[2:0]], wd, wb);
    end
    if (do_write && wsel == 4'h8 && wb[0]) begin
      ctrl_next = wd[1:0];
    end
    // whole-word refresh, wins over a same-cycle write
    if (refresh) begin
      res_next[0] = RESULTS_I.raw_tot_u;
      res_next[1] = src_b ? RESULTS_I.raw_tot_ib : RESULTS_I.raw_tot_ia;
      res_next[2] = RESULTS_I.raw_meas;
      res_next[3] = RESULTS_I.raw_fund_u;
      res_next[4] = src_b ? RESULTS_I.raw_fund_ib : RESULTS_I.raw_fund_ia;
      res_next[5] = RESULTS_I.inst_tot_u;
      res_next[6] = src_b ? RESULTS_I.inst_tot_ib : RESULTS_I.inst_tot_ia;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wst_reg     <= RRB_W_IDLE;
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 32'h0000_0000;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bresp_reg   <= 2'h0;
      res_reg     <= {NREG{`RRB_RESULT_RESET}};
      ctrl_reg    <= `RRB_CTRL_RESET;
    end else begin
      wst_reg     <= wst_next;
      aw_hold_reg <= aw_hold_next;
      w_hold_reg  <= w_hold_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bresp_reg   <= bresp_next;
      res_reg     <= res_next;
      ctrl_reg    <= ctrl_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channel
  logic        rv_reg, rv_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [3:0]  rsel;

  assign rsel = decode(AXI_REQ_I.araddr);

  always_comb begin
    rv_next    = rv_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rv_reg && AXI_REQ_I.rready) rv_next = 1'b0;
    if (!rv_reg && AXI_REQ_I.arvalid) begin
      rv_next    = 1'b1;
      rresp_next = 2'h0;
      if (rsel < 4'(NREG)) begin
        rdata_next = res_reg[rsel[2:0]];
      end else if (rsel == 4'h7) begin
        rdata_next = 32'h0000_0000;
        rdata_next[`RRB_STAT_SETTLED_BIT] = settled;
        rdata_next[`RRB_STAT_SRC_B_BIT]   = src_b;
        rdata_next[`RRB_STAT_CLK_SEL_BIT] = ctrl_reg[`RRB_CTRL_CLK_SEL_BIT];
      end else if (rsel == 4'h8) begin
        rdata_next = {30'h0, ctrl_reg};
      end else begin
        rdata_next = 32'h0000_0000;
        rresp_next = 2'h2;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rv_reg    <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= 2'h0;
    end else begin
      rv_reg    <= rv_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  always_comb begin
    AXI_RSP_O         = '0;
    AXI_RSP_O.awready = (wst_reg == RRB_W_IDLE) && !aw_hold_reg;
    AXI_RSP_O.wready  = (wst_reg == RRB_W_IDLE) && !w_hold_reg;
    AXI_RSP_O.bvalid  = (wst_reg == RRB_W_RESP);
    AXI_RSP_O.bresp   = bresp_reg;
    AXI_RSP_O.arready = !rv_reg;
    AXI_RSP_O.rvalid  = rv_reg;
    AXI_RSP_O.rdata   = rdata_reg;
    AXI_RSP_O.rresp   = rresp_reg;
  end

  assign REFRESH_O = refresh;
  assign SETTLED_O = settled;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  a_refresh_raw_u: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    refresh |=> res_reg[0] == $past(RESULTS_I.raw_tot_u))
    else $error("raw voltage not loaded on refresh");
  a_refresh_cur_src: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    refresh |=> res_reg[1] == ($past(src_b) ? $past(RESULTS_I.raw_tot_ib)
                                            : $past(RESULTS_I.raw_tot_ia)))
    else $error("raw total current source wrong");
  a_refresh_fund_i: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    refresh |=> res_reg[4] == ($past(src_b) ? $past(RESULTS_I.raw_fund_ib)
                                            : $past(RESULTS_I.raw_fund_ia)))
    else $error("fundamental current source wrong");
  a_refresh_inst_i: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    refresh |=> res_reg[6] == ($past(src_b) ? $past(RESULTS_I.inst_tot_ib)
                                            : $past(RESULTS_I.inst_tot_ia)))
    else $error("instantaneous current source wrong");
  a_refresh_meas: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    refresh |=> res_reg[2] == $past(RESULTS_I.raw_meas) &&
                res_reg[3] == $past(RESULTS_I.raw_fund_u))
    else $error("measurement or fundamental voltage not loaded");
  a_refresh_inst_u: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    refresh |=> res_reg[5] == $past(RESULTS_I.inst_tot_u))
    else $error("instantaneous voltage not loaded");
  a_hold_between: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !refresh && !do_write |=> $stable(res_reg))
    else $error("result changed without refresh or write");
  a_write_reads_back: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    do_write && !refresh && wsel == 4'h0 && wb == 4'hf |=> res_reg[0] == $past(wd))
    else $error("host write not stored");
  a_settle_not_early: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    restart |=> !settled [*8])
    else $error("settled too soon after restart");
  // refused accesses answer with an error
  a_read_refused: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !rv_reg && AXI_REQ_I.arvalid && rsel == 4'hf |=> rresp_reg == 2'h2 && rdata_reg == 32'h0)
    else $error("unmapped read not refused");
  a_status_write_err: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    do_write && wsel == 4'h7 |=> bresp_reg == 2'h2 && $stable(ctrl_reg))
    else $error("status write not refused");

endmodule : rrb_bank

//--- tb/tb_top.sv
// Self-checking bench for the RMS result bank: AXI4-Lite host tasks, random results
// Assumes rrb_pkg compiled first and rrb_cfg.svh on the include path
`include "rrb_cfg.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rrb_pkg::*;
  // Shrunk millisecond so a slow settle fits the run
  localparam int MS_CYC  = 10;
  localparam int UPD_F   = 160 * MS_CYC;
  localparam int SET_F   = 500 * MS_CYC;
  localparam int UPD_S   = 640 * MS_CYC;
  localparam int SET_S   = 2000 * MS_CYC;
  localparam int T_LIMIT = 40000;
  localparam logic [31:0] CTRL_A = {18'h0, `RRB_IDX_CTRL, 2'b00};
  localparam logic [31:0] STAT_A = {18'h0, `RRB_IDX_STATUS, 2'b00};

  logic         clk;
  logic         rst_n;
  rrb_results_t res_in;
  rrb_results_t cur;
  rrb_axi_req_t req;
  rrb_axi_rsp_t rsp;
  logic         refresh;
  logic         settled;
  int           n_mismatch;
  int           total_checks;
  int           cycles;
  int           t1;
  int           t2;
  int           ts;
  logic [31:0]  rd;
  logic [31:0]  wv;
  logic [31:0]  shadow [7];
  logic [3:0]   sb;
  logic [1:0]   code;

  rrb_bank #(.MS_CYCLES(MS_CYC)) dut_u (
    .CLK_I(clk), .RST_N_I(rst_n), .RESULTS_I(res_in), .AXI_REQ_I(req),
    .AXI_RSP_O(rsp), .REFRESH_O(refresh), .SETTLED_O(settled)
  );

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] addr_of(input int k);
    case (k)
      0: return {18'h0, `RRB_IDX_RAW_TOT_U, 2'b00};
      1: return {18'h0, `RRB_IDX_RAW_TOT_I, 2'b00};
      2: return {18'h0, `RRB_IDX_RAW_MEAS, 2'b00};
      3: return {18'h0, `RRB_IDX_RAW_FUND_U, 2'b00};
      4: return {18'h0, `RRB_IDX_RAW_FUND_I, 2'b00};
      5: return {18'h0, `RRB_IDX_INST_TOT_U, 2'b00};
      default: return {18'h0, `RRB_IDX_INST_TOT_I, 2'b00};
    endcase
  endfunction : addr_of

  // Current registers follow the selected input, the rest are fixed sources
  function automatic logic [31:0] exp_res(input int k, input rrb_results_t r, input logic b);
    case (k)
      0: return r.raw_tot_u;
      1: return b ? r.raw_tot_ib : r.raw_tot_ia;
      2: return r.raw_meas;
      3: return r.raw_fund_u;
      4: return b ? r.raw_fund_ib : r.raw_fund_ia;
      5: return r.inst_tot_u;
      default: return b ? r.inst_tot_ib : r.inst_tot_ia;
    endcase
  endfunction : exp_res

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] m;
    for (int i = 0; i < 4; i++) m[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    return m;
  endfunction : merge

  function automatic logic near(input int a, input int b);
    return (a >= b - 4) && (a <= b + 4);
  endfunction : near

  ////////////////////////////////////////////////////////////////////////////////
  // Handshakes are judged on the settled half cycle, acted on at the next rising edge
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    logic ha;
    logic hw;
    logic hb;
    hb = 1'b0;
    r  = 2'h3;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= s;
    req.bready  <= 1'b1;
    while (!hb) begin
      @(negedge clk);
      ha = req.awvalid && (rsp.awready === 1'b1);
      hw = req.wvalid && (rsp.wready === 1'b1);
      hb = (rsp.bvalid === 1'b1);
      r  = rsp.bresp;
      @(posedge clk);
      if (ha) req.awvalid <= 1'b0;
      if (hw) req.wvalid <= 1'b0;
      if (hb) req.bready <= 1'b0;
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha;
    logic hr;
    hr = 1'b0;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    while (!hr) begin
      @(negedge clk);
      ha = req.arvalid && (rsp.arready === 1'b1);
      hr = (rsp.rvalid === 1'b1);
      d  = rsp.rdata;
      r  = rsp.rresp;
      @(posedge clk);
      if (ha) req.arvalid <= 1'b0;
      if (hr) req.rready <= 1'b0;
    end
  endtask : axi_rd

  task automatic rand_res(output rrb_results_t r);
    for (int i = 0; i < 10; i++) r[i*32 +: 32] = $urandom();
  endtask : rand_res

  // Returns just after the edge at which a refresh loads
  task automatic sync_ref;
    while (refresh !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask : sync_ref

  task automatic watch(input int lim, output int r1, output int r2, output int st);
    r1 = 0;
    r2 = 0;
    st = 0;
    for (int n = 1; n <= lim; n++) begin
      @(negedge clk);
      if (refresh === 1'b1 && r1 != 0 && r2 == 0) r2 = n;
      if (refresh === 1'b1 && r1 == 0) r1 = n;
      if (settled === 1'b1 && st == 0) st = n;
    end
  endtask : watch

  task automatic check_all(input logic b, input rrb_results_t r);
    for (int k = 0; k < 7; k++) begin
      axi_rd(addr_of(k), rd, code);
      `CHK(rd, exp_res(k, r, b))
    end
  endtask : check_all

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cycles++;
    if (cycles == T_LIMIT) begin
      n_mismatch++;
      $display("MISMATCH t=%0t timeout", $time);
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    res_in = '0;
    n_mismatch = 0;
    total_checks = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    void'($urandom(32'hf92e7e9f));
    for (int k = 0; k < 7; k++) begin
      axi_rd(addr_of(k), rd, code);
      `CHK(rd, 32'h0)
      `CHK(code, 2'h0)
    end
    rand_res(cur);
    res_in <= cur;
    sync_ref();
    check_all(1'b0, cur);
    // host writes with byte lanes, corners 4'hf and 4'h0 first
    for (int k = 0; k < 7; k++) begin
      wv = $urandom();
      sb = (k == 0) ? 4'hf : (k == 1) ? 4'h0 : 4'($urandom());
      shadow[k] = merge(exp_res(k, cur, 1'b0), wv, sb);
      axi_wr(addr_of(k), wv, sb, code);
      `CHK(code, 2'h0)
      axi_rd(addr_of(k), rd, code);
      `CHK(rd, shadow[k])
    end
    // new results stay out until the refresh, then land whole
    rand_res(cur);
    res_in <= cur;
    for (int k = 0; k < 7; k++) begin
      axi_rd(addr_of(k), rd, code);
      `CHK(rd, shadow[k])
    end
    sync_ref();
    check_all(1'b0, cur);
    // Refused places and a control write without lane 0
    axi_rd(32'h0000_07fc, rd, code);
    `CHK(code, 2'h2)
    `CHK(rd, 32'h0)
    axi_rd(32'h0001_0410, rd, code);
    `CHK(code, 2'h2)
    axi_wr(STAT_A, 32'hffff_ffff, 4'hf, code);
    `CHK(code, 2'h2)
    axi_wr(CTRL_A, 32'h3, 4'he, code);
    axi_rd(CTRL_A, rd, code);
    `CHK(rd, 32'h0)
    rand_res(cur);
    res_in <= cur;
    axi_wr(CTRL_A, 32'h2, 4'hf, code);
    watch(SET_F + 20, t1, t2, ts);
    `CHK(t2 - t1, UPD_F)
    `CHK(near(t1, UPD_F), 1'b1)
    `CHK(near(ts, SET_F), 1'b1)
    check_all(1'b1, cur);
    axi_rd(STAT_A, rd, code);
    `CHK(rd, 32'h3)
    rand_res(cur);
    res_in <= cur;
    axi_wr(CTRL_A, 32'h1, 4'hf, code);
    watch(SET_S + 20, t1, t2, ts);
    `CHK(t2 - t1, UPD_S)
    `CHK(near(t1, UPD_S), 1'b1)
    `CHK(near(ts, SET_S), 1'b1)
    check_all(1'b0, cur);
    axi_rd(STAT_A, rd, code);
    `CHK(rd, 32'h5)
    give_verdict();
  end

endmodule : tb_top
